// ---- common/smt_pkg.sv ----
// Constants, field layouts and enumerations for the synchronous/static memory timing block.
// Assumes a single 200 MHz CPU clock and a half-rate memory clock derived from it.
// How it works
// - Column strobe asserts at first one-to-zero pattern edge
// - RAS-to-CAS delay is leading ones plus one
// - DRAM keeps column strobe low whole burst
// - Mask ROM strobes column only on first beat
// - Two zeros delay latching, only with divide clear
// - Reserved config bits ignore writes, read zero
// - Two-bit ROM type selects static memory flavour
// - Burst types: aligned beats slow, others fast
// - Static read bursts aligned to burst length
// - Precharge-all drives documented pin levels
package smt_pkg;
    localparam int          PAT_W          = 32;       // Waveform pattern width
    localparam int          ADDR_W         = 26;       // Request address width
    localparam int          DATA_W         = 32;       // Data word width
    localparam int          BEAT_W         = 4;        // Beat counter width
    localparam int          CNT_W          = 6;        // Access time counter width
    localparam int          REFR_W         = 32;       // Refresh control width
    localparam int          SROM_W         = 32;       // Sync ROM config width
    localparam logic [31:0] REFR_MASK      = 32'h03ff_ffff; // Implemented refresh bits
    localparam logic [31:0] SROM_MASK      = 32'h7fff_7fff; // Implemented ROM cfg bits
    localparam int          REFR_DIV_BIT   = 25;       // Half-clock divide select position
    localparam logic [3:0]  MASK_PRECHARGE_ALL_CMD      = 4'h0;     // Byte masks during precharge-all
    localparam int          ROW_A10        = 10;       // Row address bit ten position
    localparam logic [CNT_W-1:0] NONBURST_T = 6'h08;   // Nonburst access cycles
    localparam logic [CNT_W-1:0] BURST_T    = 6'h03;   // Burst beat access cycles
    localparam int          BUF_DEPTH      = 2;        // Read data buffer depth

    // Static ROM type field encodings
    typedef enum logic [1:0] {
        ROM_NONBURST  = 2'h0,
        ROM_SRAM_VLIO = 2'h1,
        ROM_BURST4    = 2'h2,
        ROM_BURST8    = 2'h3
    } smt_rom_type;

    // Controller state encodings
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_SYNC   = 3'h1,
        ST_STATIC = 3'h2,
        ST_PRECHARGE_ALL_CMD   = 3'h3,
        ST_PALL2  = 3'h4
    } smt_state_type;
endpackage : smt_pkg

// ---- hdl/smt_buf.sv ----
// Two-entry valid/ready buffer holding read data words.
// Assumes both sides on clk_i; drain side may stall at will.
`timescale 1ns/1ps
module smt_buf
    import smt_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              in_valid_i,
    output logic                   in_ready_o,
    input  wire logic [DATA_W-1:0] in_data_i,
    output logic                   out_valid_o,
    input  wire logic              out_ready_i,
    output logic [DATA_W-1:0]      out_data_o
);
    // Whole state in one struct
    typedef struct packed {
        logic [1:0][DATA_W-1:0] mem;   // Storage entries
        logic                   wp;    // Write pointer
        logic                   rp;    // Read pointer
        logic [1:0]             cnt;   // Occupancy
    } smt_buf_type;

    smt_buf_type s_q;    // Registered state
    smt_buf_type s_d;    // Next state
    logic        push;   // Word accepted
    logic        pop;    // Word drained

    assign in_ready_o  = (s_q.cnt != 2'h2);
    assign out_valid_o = (s_q.cnt != 2'h0);
    assign out_data_o  = s_q.mem[s_q.rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Pointer and count update
    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wp] = in_data_i;
            s_d.wp          = ~s_q.wp;
        end
        if (pop)
            s_d.rp = ~s_q.rp;
        // Simultaneous push and pop keeps count
        if (push && !pop)
            s_d.cnt = s_q.cnt + 2'h1;
        else if (pop && !push)
            s_d.cnt = s_q.cnt - 2'h1;
    end

    // State register
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end
endmodule : smt_buf

// ---- hdl/smt_ctrl.sv ----
// Memory timing controller: sync DRAM / mask ROM strobes and static bank access timing.
// Assumes the request side is on clk_i; memory read data passes a two-flop sync.
`timescale 1ns/1ps
module smt_ctrl
    import smt_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    // Configuration
    input  wire logic [PAT_W-1:0]       cas_waveform_pattern_i,
    input  wire logic                   refr_wr_i,
    input  wire logic [REFR_W-1:0]      refr_wdata_i,
    output logic [REFR_W-1:0]           refresh_control_reg_o,
    input  wire logic                   srom_wr_i,
    input  wire logic [SROM_W-1:0]      srom_wdata_i,
    output logic [SROM_W-1:0]           sync_rom_config_reg_o,
    input  wire logic [1:0]             rom_type_field_i,
    input  wire logic                   sync_is_rom_i,
    // Requests
    input  wire logic                   req_valid_i,
    output logic                        req_ready_o,
    input  wire logic                   req_sync_i,
    input  wire logic                   req_precharge_all_cmd_i,
    input  wire logic [ADDR_W-1:0]      req_addr_i,
    input  wire logic [BEAT_W-1:0]      req_beats_i,
    // Read data out
    output logic                        rd_valid_o,
    input  wire logic                   rd_ready_i,
    output logic [DATA_W-1:0]           rd_data_o,
    // Status
    output logic                        busy_o,
    output logic                        delayed_latch_o,
    output logic [BEAT_W-1:0]           ras_cas_ones_o,
    // Memory pins
    input  wire logic [DATA_W-1:0]      mem_data_i,
    output logic                        row_strobe_chip_select_n_o,
    output logic                        sync_row_strobe_o,
    output logic                        sync_column_strobe_n_o,
    output logic                        write_strobe_n_o,
    output logic [3:0]                  byte_mask_lines_o,
    output logic                        row_addr_bit10_o,
    output logic                        memory_clock_enable_o,
    output logic                        memory_clock_out_o,
    output logic                        static_chip_select_n_o,
    output logic [ADDR_W-1:0]           mem_addr_o
);
    // Whole state in one struct
    typedef struct packed {
        smt_state_type      st;      // Controller state
        logic [PAT_W-1:0]   shreg;   // Pattern being shifted out
        logic               prev;    // Last pattern bit driven
        logic               cas_seen; // Column strobe already asserted
        logic [BEAT_W-1:0]  beats;   // Beats remaining
        logic [CNT_W-1:0]   tmr;     // Access cycle counter
        logic [ADDR_W-1:0]  addr;    // Current beat address
        logic [REFR_W-1:0]  refr;    // Refresh control register
        logic [SROM_W-1:0]  srom;    // Sync ROM config register
        logic               clk_div; // Half-rate memory clock
        logic               rcs_n;   // Row strobe / chip select
        logic               rras;    // Sync row strobe, low when asserted
        logic               cas_n;   // Column strobe
        logic               we_n;    // Write strobe
        logic [3:0]         mask;    // Byte masks
        logic               a10;     // Row address bit ten
        logic               cs_n;    // Static chip select
        logic               push;    // Beat data capture
        logic [DATA_W-1:0]  wd;      // Captured read word
        logic [DATA_W-1:0]  sy1;     // Read data sync stage one
        logic [DATA_W-1:0]  sy2;     // Read data sync stage two
    } smt_ctrl_type;

    smt_ctrl_type s_q;         // Registered state
    smt_ctrl_type s_d;         // Next state
    logic         buf_ready;   // Buffer can take a word
    logic         div_sel;     // Half-clock divide select
    logic [BEAT_W-1:0] ones;   // Leading one count
    logic         two_zero;    // Two zeros after leading ones
    logic [BEAT_W-1:0] align;  // Burst alignment mask

    assign div_sel = s_q.refr[REFR_DIV_BIT];

    // Count leading ones and the zero gap from the pattern
    always_comb
    begin
        ones = '0;
        two_zero = 1'b0;
        for (int i = 0; i < 15; i++)
        begin
            if (cas_waveform_pattern_i[i] && (ones == BEAT_W'(i)))
                ones = ones + 4'h1;
        end
        two_zero = !cas_waveform_pattern_i[ones] && !cas_waveform_pattern_i[ones + 4'h1];
    end

    // Burst alignment per ROM type
    always_comb
    begin
        case (rom_type_field_i)
            ROM_BURST4: align = 4'h3;
            ROM_BURST8: align = 4'h7;
            default:    align = 4'h0;
        endcase
    end

    // Next-state logic
    always_comb
    begin
        s_d = s_q;
        s_d.push = 1'b0;
        s_d.sy1 = mem_data_i;
        s_d.sy2 = s_q.sy1;
        s_d.clk_div = ~s_q.clk_div;
        if (refr_wr_i)
            s_d.refr = refr_wdata_i & REFR_MASK;
        if (srom_wr_i)
            s_d.srom = srom_wdata_i & SROM_MASK;
        case (s_q.st)
            ST_IDLE:
            begin
                s_d.rcs_n = 1'b1;
                s_d.rras = 1'b1; // Row strobe idles high like the other strobes
                s_d.cas_n = 1'b1;
                s_d.we_n = 1'b1;
                s_d.mask = 4'hf;
                s_d.a10 = 1'b0;
                s_d.cs_n = 1'b1;
                if (req_valid_i && buf_ready)
                begin
                    s_d.beats = req_beats_i;
                    s_d.cas_seen = 1'b0;
                    s_d.prev = 1'b1;
                    if (req_precharge_all_cmd_i)
                        s_d.st = ST_PRECHARGE_ALL_CMD; // CKE stays high the cycle before
                    else if (req_sync_i)
                    begin
                        s_d.st = ST_SYNC;
                        s_d.rcs_n = 1'b0;
                        s_d.rras = 1'b0;
                        s_d.shreg = cas_waveform_pattern_i;
                        s_d.addr = req_addr_i;
                    end
                    else
                    begin
                        s_d.st = ST_STATIC;
                        s_d.cs_n = 1'b0;
                        s_d.tmr = NONBURST_T;
                        // Aligned start for read bursts
                        s_d.addr = req_addr_i & ~ADDR_W'(align);
                    end
                end
            end
            ST_SYNC:
            begin
                s_d.rras = 1'b1;
                // One pattern bit per cycle, LSB first
                s_d.shreg = {1'b1, s_q.shreg[PAT_W-1:1]};
                s_d.prev = s_q.shreg[0];
                if (s_q.prev && !s_q.shreg[0] && !s_q.cas_seen)
                begin
                    s_d.cas_n = 1'b0;
                    s_d.cas_seen = 1'b1;
                end
                else if (s_q.cas_seen && sync_is_rom_i)
                    s_d.cas_n = 1'b1;
                // DRAM holds column strobe low for the burst
                else if (s_q.cas_seen)
                    s_d.cas_n = 1'b0;
                if (s_q.cas_seen && !s_q.prev && s_q.shreg[0])
                begin
                    s_d.push = 1'b1;
                    s_d.wd = s_q.sy2;
                    s_d.addr = s_q.addr + ADDR_W'(1);
                    if (s_q.beats <= 4'h1)
                        s_d.st = ST_IDLE;
                    else
                        s_d.beats = s_q.beats - 4'h1;
                end
            end
            ST_STATIC:
            begin
                if (s_q.tmr <= 6'h1)
                begin
                    s_d.push = 1'b1;
                    s_d.wd = s_q.sy2;
                    s_d.addr = s_q.addr + ADDR_W'(1);
                    // Aligned beats take nonburst time
                    if (align == 4'h0 || ((s_q.addr[BEAT_W-1:0] + 4'h1) & align) == 4'h0)
                        s_d.tmr = NONBURST_T;
                    else
                        s_d.tmr = BURST_T;
                    if (s_q.beats <= 4'h1)
                        s_d.st = ST_IDLE;
                    else
                        s_d.beats = s_q.beats - 4'h1;
                end
                else
                    s_d.tmr = s_q.tmr - 6'h1;
            end
            ST_PRECHARGE_ALL_CMD:
            begin
                // Precharge-all pin levels
                s_d.rcs_n = 1'b0;
                s_d.rras = 1'b0;
                s_d.cas_n = 1'b1;
                s_d.we_n = 1'b0;
                s_d.mask = MASK_PRECHARGE_ALL_CMD;
                s_d.a10 = 1'b1;
                s_d.st = ST_PALL2;
            end
            ST_PALL2:
                s_d.st = ST_IDLE;
            default:
                s_d.st = ST_IDLE;
        endcase
        // Push is dropped, not held, when buffer full; request gate keeps room
        if (s_d.push && !buf_ready)
            s_d.push = 1'b0;
    end

    // State register
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s_q <= '0;
            s_q.rcs_n <= 1'b1;
            s_q.rras <= 1'b1;
            s_q.cas_n <= 1'b1;
            s_q.we_n <= 1'b1;
            s_q.mask <= 4'hf;
            s_q.cs_n <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    // Read data buffer
    smt_buf u_buf (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (s_q.push),
        .in_ready_o  (buf_ready),
        .in_data_i   (s_q.wd),
        .out_valid_o (rd_valid_o),
        .out_ready_i (rd_ready_i),
        .out_data_o  (rd_data_o)
    );

    assign req_ready_o = (s_q.st == ST_IDLE) && buf_ready;
    assign busy_o = (s_q.st != ST_IDLE);
    // Delayed latching only honoured with divide clear
    assign delayed_latch_o = two_zero && !div_sel;
    assign ras_cas_ones_o = ones;
    assign refresh_control_reg_o = s_q.refr;
    assign sync_rom_config_reg_o = s_q.srom;
    assign row_strobe_chip_select_n_o = s_q.rcs_n;
    assign sync_row_strobe_o = s_q.rras;
    assign sync_column_strobe_n_o = s_q.cas_n;
    assign write_strobe_n_o = s_q.we_n;
    assign byte_mask_lines_o = s_q.mask;
    assign row_addr_bit10_o = s_q.a10;
    assign memory_clock_enable_o = 1'b1;
    assign memory_clock_out_o = s_q.clk_div;
    assign static_chip_select_n_o = s_q.cs_n;
    assign mem_addr_o = s_q.addr;
endmodule : smt_ctrl

// ---- tb/smt_ctrl_monitor.sv ----
// Checker for the memory timing controller ports: strobes, precharge pins, config masks.
// Assumes one clock domain; bound into every smt_ctrl instance.
`timescale 1ns/1ps
module smt_ctrl_monitor
    import smt_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              sys_rst_i,
    input wire logic              refr_wr_i,
    input wire logic [REFR_W-1:0] refr_wdata_i,
    input wire logic [REFR_W-1:0] refresh_control_reg_o,
    input wire logic              srom_wr_i,
    input wire logic [SROM_W-1:0] srom_wdata_i,
    input wire logic [SROM_W-1:0] sync_rom_config_reg_o,
    input wire logic              sync_is_rom_i,
    input wire logic              delayed_latch_o,
    input wire logic [BEAT_W-1:0] ras_cas_ones_o,
    input wire logic              row_strobe_chip_select_n_o,
    input wire logic              sync_row_strobe_o,
    input wire logic              sync_column_strobe_n_o,
    input wire logic              write_strobe_n_o,
    input wire logic [3:0]        byte_mask_lines_o,
    input wire logic              row_addr_bit10_o,
    input wire logic              memory_clock_enable_o
);
    logic [7:0] ras_cnt_q; // Cycles since row strobe went low
    // Counter restarts whenever the row strobe is released
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            ras_cnt_q <= 8'h00;
        else if (row_strobe_chip_select_n_o)
            ras_cnt_q <= 8'h00;
        else
            ras_cnt_q <= ras_cnt_q + 8'h01;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    ras_cas_a: assert property ($fell(sync_column_strobe_n_o) |->
        ras_cnt_q == {4'h0, ras_cas_ones_o} + 8'h01) else $error("column strobe delay wrong");
    precharge_all_cmd_pins_a: assert property (!row_strobe_chip_select_n_o && !write_strobe_n_o |->
        !sync_row_strobe_o && sync_column_strobe_n_o && byte_mask_lines_o == 4'h0
        && row_addr_bit10_o && $past(memory_clock_enable_o)) else $error("precharge pins wrong");
    cke_high_a: assert property (memory_clock_enable_o)
        else $error("clock enable low");
    refr_mask_a: assert property (refr_wr_i |=>
        refresh_control_reg_o == ($past(refr_wdata_i) & REFR_MASK)) else $error("refresh write");
    srom_mask_a: assert property (srom_wr_i |=>
        sync_rom_config_reg_o == ($past(srom_wdata_i) & SROM_MASK)) else $error("rom cfg write");
    rsvd_zero_a: assert property ((refresh_control_reg_o & ~REFR_MASK) == 0
        && (sync_rom_config_reg_o & ~SROM_MASK) == 0) else $error("reserved bits set");
    latch_div_a: assert property (delayed_latch_o |->
        !refresh_control_reg_o[REFR_DIV_BIT]) else $error("delayed latch with divide set");
    dram_hold_a: assert property (!sync_is_rom_i && $rose(sync_column_strobe_n_o) |->
        row_strobe_chip_select_n_o) else $error("column strobe dropped in burst");
    rom_first_a: assert property (sync_is_rom_i && $fell(sync_column_strobe_n_o) |->
        ##[1:3] sync_column_strobe_n_o) else $error("rom column strobe held");
    // Main scenarios reached
    precharge_all_cmd_c: cover property (!row_strobe_chip_select_n_o && !write_strobe_n_o);
    dlat_c: cover property (delayed_latch_o && $fell(sync_column_strobe_n_o));
    rom_c: cover property (sync_is_rom_i && $fell(sync_column_strobe_n_o));
endmodule : smt_ctrl_monitor

bind smt_ctrl smt_ctrl_monitor smt_ctrl_monitor_inst (.clk_i, .sys_rst_i, .refr_wr_i,
    .refr_wdata_i, .refresh_control_reg_o, .srom_wr_i, .srom_wdata_i, .sync_rom_config_reg_o,
    .sync_is_rom_i, .delayed_latch_o, .ras_cas_ones_o, .row_strobe_chip_select_n_o,
    .sync_row_strobe_o, .sync_column_strobe_n_o, .write_strobe_n_o, .byte_mask_lines_o,
    .row_addr_bit10_o, .memory_clock_enable_o);

// ---- tb/smt_mem_model.sv ----
// Behavioural memory answering reads with a word made from the address.
// Assumes active-low selects; an unselected bus toggles so stale words never match.
`timescale 1ns/1ps
module smt_mem_model
    import smt_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              slow_i,
    input  wire logic              row_strobe_chip_select_n_i,
    input  wire logic              static_chip_select_n_i,
    input  wire logic [ADDR_W-1:0] mem_addr_i,
    output logic [DATA_W-1:0]      mem_data_o
);
    logic [DATA_W-1:0] near_q = 32'h5a5a_5a5a; // Word one cycle after address
    logic [DATA_W-1:0] far_q  = 32'ha5a5_a5a5; // Slow answer, one cycle later
    // Released bus shows the inverse each cycle
    always @(posedge clk_i)
    begin
        if (!row_strobe_chip_select_n_i || !static_chip_select_n_i)
            near_q <= {{(DATA_W-ADDR_W){1'b0}}, mem_addr_i};
        else
            near_q <= ~near_q;
        far_q <= near_q;
    end
    assign mem_data_o = slow_i ? far_q : near_q;
endmodule : smt_mem_model

// ---- tb/smt_ctrl_tb.sv ----
// Bench for the memory timing controller: sync strobes, static timing, config masks.
// Assumes the memory model answers every read; no static writes are issued.
`timescale 1ns/1ps
module smt_ctrl_tb;
    import smt_pkg::*;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, slow_i = 1'b0;
    logic refr_wr_i = 1'b0, srom_wr_i = 1'b0, sync_is_rom_i = 1'b0;
    logic [31:0] refr_wdata_i = '0, srom_wdata_i = '0, cas_waveform_pattern_i = '0;
    logic [1:0]  rom_type_field_i = '0;
    logic req_valid_i = 1'b0, req_sync_i = 1'b0, req_precharge_all_cmd_i = 1'b0, rd_ready_i = 1'b0;
    logic [ADDR_W-1:0] req_addr_i = '0, mem_addr_o;
    logic [BEAT_W-1:0] req_beats_i = '0, ras_cas_ones_o;
    logic [31:0] refresh_control_reg_o, sync_rom_config_reg_o, rd_data_o, mem_data_i;
    logic req_ready_o, rd_valid_o, busy_o, delayed_latch_o, row_strobe_chip_select_n_o;
    logic sync_row_strobe_o, sync_column_strobe_n_o, write_strobe_n_o, row_addr_bit10_o;
    logic memory_clock_enable_o, memory_clock_out_o, static_chip_select_n_o;
    logic [3:0] byte_mask_lines_o;
    int fail_count = 0, num_checks = 0;
    always #2.5 clk_i = ~clk_i;
    smt_ctrl smt_ctrl_inst (.clk_i, .sys_rst_i, .cas_waveform_pattern_i, .refr_wr_i,
        .refr_wdata_i, .refresh_control_reg_o, .srom_wr_i, .srom_wdata_i,
        .sync_rom_config_reg_o, .rom_type_field_i, .sync_is_rom_i, .req_valid_i, .req_ready_o,
        .req_sync_i, .req_precharge_all_cmd_i, .req_addr_i, .req_beats_i, .rd_valid_o, .rd_ready_i,
        .rd_data_o, .busy_o, .delayed_latch_o, .ras_cas_ones_o, .mem_data_i,
        .row_strobe_chip_select_n_o, .sync_row_strobe_o, .sync_column_strobe_n_o,
        .write_strobe_n_o, .byte_mask_lines_o, .row_addr_bit10_o, .memory_clock_enable_o,
        .memory_clock_out_o, .static_chip_select_n_o, .mem_addr_o);
    smt_mem_model smt_mem_model_inst (.clk_i, .slow_i, .mem_addr_i(mem_addr_o),
        .row_strobe_chip_select_n_i(row_strobe_chip_select_n_o),
        .static_chip_select_n_i(static_chip_select_n_o), .mem_data_o(mem_data_i));
    // Value compare with four-state equality
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // Request held until ready seen, then dropped at the taking edge
    task automatic req(input logic s, input logic p, input logic [BEAT_W-1:0] n);
        int k;
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_sync_i  <= s;
        req_precharge_all_cmd_i  <= p;
        req_beats_i <= n;
        k = 0;
        @(negedge clk_i);
        while (req_ready_o !== 1'b1 && k < 100)
        begin
            @(negedge clk_i);
            k++;
        end
        @(posedge clk_i);
        req_valid_i <= 1'b0;
    endtask : req
    // Bounded wait for the controller to settle back to idle
    task automatic idle();
        int k;
        k = 0;
        @(negedge clk_i);
        while (busy_o !== 1'b0 && k < 200)
        begin
            @(negedge clk_i);
            k++;
        end
        repeat (4) @(negedge clk_i);
    endtask : idle
    task automatic wr_div(input logic d);
        @(posedge clk_i);
        refr_wr_i    <= 1'b1;
        refr_wdata_i <= {6'h00, d, 25'h0};
        @(posedge clk_i);
        refr_wr_i    <= 1'b0;
    endtask : wr_div
    // Reset values, then all-ones writes must land only on implemented bits
    task automatic t_regs();
        logic m;
        chk(refresh_control_reg_o, 32'h0, "refresh reset");
        chk(sync_rom_config_reg_o, 32'h0, "rom cfg reset");
        @(posedge clk_i);
        refr_wr_i    <= 1'b1;
        srom_wr_i    <= 1'b1;
        refr_wdata_i <= '1;
        srom_wdata_i <= '1;
        @(posedge clk_i);
        refr_wr_i    <= 1'b0;
        srom_wr_i    <= 1'b0;
        @(negedge clk_i);
        chk(refresh_control_reg_o, REFR_MASK, "refresh mask");
        chk(sync_rom_config_reg_o, SROM_MASK, "rom cfg mask");
        m = memory_clock_out_o;
        @(negedge clk_i);
        chk(memory_clock_out_o, {31'h0, ~m}, "memory clock toggle");
        $display("test regs done");
    endtask : t_regs
    // Two-beat sync read with the receiver stalled until the buffer is full
    task automatic t_sync(input logic [31:0] pat, input logic rom, input logic dv,
                          input logic [3:0] ones, input logic dl);
        int w;
        wr_div(dv);
        cas_waveform_pattern_i <= pat;
        sync_is_rom_i          <= rom;
        rd_ready_i             <= 1'b0;
        @(negedge clk_i);
        chk(ras_cas_ones_o, ones, "leading ones");
        chk(delayed_latch_o, dl, "delayed latch");
        req(1'b1, 1'b0, 4'h2);
        idle();
        chk(req_ready_o, 1'b0, "full buffer refuses");
        @(posedge clk_i);
        rd_ready_i <= 1'b1;
        w = 0;
        repeat (8) @(negedge clk_i) w += (rd_valid_o === 1'b1);
        chk(w, 2, "sync words");
        $display("test sync %h done", pat);
    endtask : t_sync
    // Precharge-all pin levels
    task automatic t_precharge_all_cmd();
        int k;
        req(1'b0, 1'b1, 4'h1);
        k = 0;
        @(negedge clk_i);
        while (row_strobe_chip_select_n_o !== 1'b0 && k < 20)
        begin
            @(negedge clk_i);
            k++;
        end
        chk({sync_row_strobe_o, sync_column_strobe_n_o, write_strobe_n_o, row_addr_bit10_o,
             memory_clock_enable_o}, 5'b01011, "precharge strobes");
        chk(byte_mask_lines_o, 4'h0, "precharge masks");
        idle();
        $display("test precharge done");
    endtask : t_precharge_all_cmd
    // Two-beat static read; burst types give a short second beat
    task automatic t_static(input logic [1:0] rt);
        int k, g, w;
        logic [DATA_W-1:0] d, e;
        @(posedge clk_i);
        rom_type_field_i <= rt;
        req_addr_i       <= 26'hd;
        slow_i           <= rt[0];
        rd_ready_i       <= 1'b1;
        req(1'b0, 1'b0, 4'h2);
        k = 0;
        g = 0;
        w = 0;
        while (w < 2 && k < 100)
        begin
            @(negedge clk_i);
            k++;
            g += (w == 1);
            // First word carries the address the memory saw
            if (w == 0 && rd_valid_o === 1'b1)
                d = rd_data_o;
            w += (rd_valid_o === 1'b1);
        end
        chk(w, 2, "static beats");
        e = (rt == 2'h2) ? 32'hc : ((rt == 2'h3) ? 32'h8 : 32'hd);
        chk(d, e, "aligned first word");
        chk(g < NONBURST_T, rt[1], "beat spacing");
        idle();
        $display("test static type %0d done", rt);
    endtask : t_static
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_sync(32'haaaa_aaa7, 1'b0, 1'b0, 4'd3, 1'b1);
        t_sync(32'haaaa_aa9f, 1'b0, 1'b0, 4'd5, 1'b1);
        t_sync(32'haaaa_aaa7, 1'b0, 1'b1, 4'd3, 1'b0);
        t_sync(32'h5555_557f, 1'b1, 1'b1, 4'd7, 1'b0);
        t_sync(32'h5555_57ff, 1'b0, 1'b1, 4'd11, 1'b0);
        t_sync(32'h5555_5557, 1'b1, 1'b0, 4'd3, 1'b0);
        t_precharge_all_cmd();
        for (int t = 0; t < 4; t++)
            t_static(t[1:0]);
        finish_test();
    end
    // Watchdog well beyond the expected run length
    initial
    begin
        #200000;
        fail_count++;
        finish_test();
    end
endmodule : smt_ctrl_tb
